// ---- core/frow_top.sv ----
// Purpose: ram overlay of small-block flash plus writer-mode pin port
// Assumes: flash array is modelled by an internal byte array, program
//          clears bits only, erase sets all bytes to blank
// Notes: writer pins cross in through two flops before use
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module frow_top #(
   parameter int FLASH_AW = 17,
   parameter int RAM_AW = 9
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hw_standby,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu memory port, one-cycle read latency
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_ram_hit,
   // writer pins
   input wire logic writer_mode,
   input wire frow_pkg::frow_pin_s pin_in,
   output logic [7:0] data_out,
   output logic data_oe_n
);
   localparam int FDEPTH = 1 << FLASH_AW;
   localparam int RDEPTH = 1 << RAM_AW;

   typedef struct packed {
      logic aw_ok;
      logic w_ok;
      logic [7:0] awa;
      logic [7:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ovl;
      frow_pkg::frow_pin_s p1;
      frow_pkg::frow_pin_s p2;
      logic we_prev;
      frow_pkg::frow_wst_e st;
      logic [16:0] tgt;
      logic [7:0] vfy;
      logic [7:0] dout;
      logic oe_n;
      logic [7:0] crd;
      logic chit;
   } frow_state_s;

   frow_state_s cur_ff, nxt_ff;
   logic [7:0] flash_mem [FDEPTH];
   logic [7:0] ram_mem [RDEPTH];
   logic [FLASH_AW-1:0] fwa;
   logic [7:0] fwd;
   logic fw_en, erase_all;
   logic [RAM_AW-1:0] rwa;
   logic rw_en;
   logic ovl_hit;
   logic [15:0] ram_ofs;
   logic [1:0] sel;
   logic [7:0] ovl_wr;

   assign sel = cur_ff.ovl[frow_pkg::OVL_SEL_HI:frow_pkg::OVL_SEL_LO];

   // overlay decode of a cpu flash address to a ram offset
   always_comb begin
      ovl_hit = 1'b0;
      ram_ofs = 16'h0000;
      case (sel)
         2'b01: begin
            ovl_hit = cpu_addr >= frow_pkg::OFS_MID &&
               cpu_addr <= frow_pkg::END_MID;
            ram_ofs = cpu_addr - frow_pkg::OFS_MID +
               (frow_pkg::RAM_MID - frow_pkg::RAM_BASE);
         end
         2'b10: begin
            ovl_hit = cpu_addr >= frow_pkg::OFS_MID &&
               cpu_addr <= frow_pkg::END_BIG;
            ram_ofs = cpu_addr - frow_pkg::OFS_MID +
               (frow_pkg::RAM_MID - frow_pkg::RAM_BASE);
         end
         2'b11: begin
            ovl_hit = cpu_addr <= frow_pkg::END_SMALL;
            ram_ofs = cpu_addr - frow_pkg::OFS_LO;
         end
         default: begin
            ovl_hit = 1'b0;
            ram_ofs = 16'h0000;
         end
      endcase
      // native ram window always reachable as well
      if (cpu_addr >= frow_pkg::RAM_BASE && cpu_addr <= frow_pkg::RAM_LAST) begin
         ovl_hit = 1'b1;
         ram_ofs = cpu_addr - frow_pkg::RAM_BASE;
      end
   end

   // main next-state logic
   always_comb begin
      frow_pkg::frow_pin_s p;
      logic we_rise;
      logic [7:0] cmd;
      p = cur_ff.p2;
      cmd = p.data;
      we_rise = 1'b0;
      nxt_ff = cur_ff;
      fw_en = 1'b0;
      erase_all = 1'b0;
      fwa = p.addr[FLASH_AW-1:0];
      fwd = p.data;
      rw_en = 1'b0;
      rwa = ram_ofs[RAM_AW-1:0];
      ovl_wr = cur_ff.ovl;
      // pin synchroniser
      nxt_ff.p1 = pin_in;
      nxt_ff.p2 = cur_ff.p1;
      nxt_ff.we_prev = p.wr_strobe_n;
      we_rise = p.wr_strobe_n && !cur_ff.we_prev && !p.chip_sel_n;
      // axi write side, address and data in either order
      if (s_axi_awvalid && !cur_ff.aw_ok) begin
         nxt_ff.aw_ok = 1'b1;
         nxt_ff.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur_ff.w_ok) begin
         nxt_ff.w_ok = 1'b1;
         nxt_ff.wd = s_axi_wdata[7:0];
         nxt_ff.ws = s_axi_wstrb;
      end
      if (cur_ff.aw_ok && cur_ff.w_ok && !cur_ff.bvalid) begin
         nxt_ff.aw_ok = 1'b0;
         nxt_ff.w_ok = 1'b0;
         nxt_ff.bvalid = 1'b1;
         nxt_ff.bresp = frow_pkg::RESP_OK;
         if (cur_ff.awa == frow_pkg::REG_OVL) begin
            if (cur_ff.ws[0])
               nxt_ff.ovl = cur_ff.wd;
         end else if (cur_ff.awa != frow_pkg::REG_WST &&
               cur_ff.awa != frow_pkg::REG_WTR)
            nxt_ff.bresp = frow_pkg::RESP_ERR;
      end
      if (cur_ff.bvalid && s_axi_bready)
         nxt_ff.bvalid = 1'b0;
      // axi read side
      if (s_axi_arvalid && !cur_ff.rvalid) begin
         nxt_ff.rvalid = 1'b1;
         nxt_ff.rresp = frow_pkg::RESP_OK;
         case (s_axi_araddr)
            frow_pkg::REG_OVL: nxt_ff.rdata = {24'h000000, cur_ff.ovl};
            frow_pkg::REG_WST: nxt_ff.rdata = {26'h0000000, cur_ff.st};
            frow_pkg::REG_WTR: nxt_ff.rdata = {15'h0000, cur_ff.tgt};
            default: begin
               nxt_ff.rdata = 32'h00000000;
               nxt_ff.rresp = frow_pkg::RESP_ERR;
            end
         endcase
      end else if (cur_ff.rvalid && s_axi_rready)
         nxt_ff.rvalid = 1'b0;
      // cpu port: overlaid and native ram, else flash
      nxt_ff.chit = cpu_req && ovl_hit;
      if (cpu_req && ovl_hit) begin
         nxt_ff.crd = ram_mem[rwa];
         rw_en = cpu_we;
      end else if (cpu_req)
         nxt_ff.crd = flash_mem[cpu_addr];
      // writer mode command sequencer
      if (!writer_mode || !p.vpp_present) begin
         nxt_ff.st = frow_pkg::WS_IDLE;
      end else if (we_rise && p.high_voltage_pin && p.out_gate_n) begin
         nxt_ff.st = frow_pkg::WS_IDLE;
         case (cur_ff.st)
            frow_pkg::WS_ERSU: if (cmd == frow_pkg::CMD_ERASE)
               erase_all = 1'b1;
            frow_pkg::WS_AESU: if (cmd == frow_pkg::CMD_AERASE)
               erase_all = 1'b1;
            frow_pkg::WS_PRSU: begin
               fw_en = 1'b1;
               fwd = flash_mem[p.addr[FLASH_AW-1:0]] & p.data;
               nxt_ff.tgt = p.addr;
            end
            default: begin
               case (cmd)
                  frow_pkg::CMD_READ: nxt_ff.st = frow_pkg::WS_READ;
                  frow_pkg::CMD_ERASE: nxt_ff.st = frow_pkg::WS_ERSU;
                  frow_pkg::CMD_AERASE: nxt_ff.st = frow_pkg::WS_AESU;
                  frow_pkg::CMD_PROG: nxt_ff.st = frow_pkg::WS_PRSU;
                  frow_pkg::CMD_PVFY: begin
                     nxt_ff.st = frow_pkg::WS_VFY;
                     nxt_ff.vfy = flash_mem[cur_ff.tgt[FLASH_AW-1:0]];
                  end
                  frow_pkg::CMD_EVFY: begin
                     nxt_ff.st = frow_pkg::WS_VFY;
                     nxt_ff.vfy = flash_mem[p.addr[FLASH_AW-1:0]];
                  end
                  default: nxt_ff.st = frow_pkg::WS_IDLE; // ff resets
               endcase
            end
         endcase
      end
      // output drive, same in read and command-write states
      nxt_ff.oe_n = !(writer_mode && p.vpp_present && !p.chip_sel_n &&
         !p.out_gate_n && p.wr_strobe_n);
      if (cur_ff.st == frow_pkg::WS_VFY)
         nxt_ff.dout = cur_ff.vfy;
      else
         nxt_ff.dout = flash_mem[p.addr[FLASH_AW-1:0]];
      // reset and hardware standby restore, soft standby
      if (hw_standby) begin
         nxt_ff.ovl = frow_pkg::OVL_RESET;
         nxt_ff.st = frow_pkg::WS_IDLE;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_ff <= '0;
         cur_ff.ovl <= frow_pkg::OVL_RESET;
         cur_ff.st <= frow_pkg::WS_IDLE;
         cur_ff.we_prev <= 1'b1;
         cur_ff.p1.wr_strobe_n <= 1'b1;
         cur_ff.p2.wr_strobe_n <= 1'b1;
         cur_ff.oe_n <= 1'b1;
      end else if (ce) begin
         cur_ff <= nxt_ff;
      end
   end

   // memories; erased and unwritten flash reads blank
   always_ff @(posedge clk) begin
      if (rst || (ce && erase_all)) begin
         for (int i = 0; i < FDEPTH; i++)
            flash_mem[i] <= frow_pkg::BLANK;
      end else if (ce && fw_en) begin
         flash_mem[fwa] <= fwd;
      end
   end

   // overlay ram storage
   always_ff @(posedge clk) begin
      if (ce && rw_en)
         ram_mem[rwa] <= cpu_wdata;
   end

   // outputs straight from state
   assign s_axi_awready = !cur_ff.aw_ok;
   assign s_axi_wready = !cur_ff.w_ok;
   assign s_axi_bvalid = cur_ff.bvalid;
   assign s_axi_bresp = cur_ff.bresp;
   assign s_axi_arready = !cur_ff.rvalid;
   assign s_axi_rvalid = cur_ff.rvalid;
   assign s_axi_rdata = cur_ff.rdata;
   assign s_axi_rresp = cur_ff.rresp;
   assign cpu_rdata = cur_ff.crd;
   assign cpu_ram_hit = cur_ff.chit;
   assign data_out = cur_ff.dout;
   assign data_oe_n = cur_ff.oe_n;
endmodule

// ---- core/frow_pkg.sv ----
// Purpose: shared constants and carriers for the flash ram overlap and
//          writer port block
// Assumes: 32-bit axi4-lite register bus, byte-wide writer pins
// Notes: register offsets are byte addresses
//
// How it works
// - The two upper bits of the overlap control register pick a ram window laid over the small-block flash.
// - While an overlay is on, the same ram cells answer at the flash address and at their own ram address.
// - Code 00 is off, 01 maps f880-f8ff at 0080-00ff, 10 maps f880-f97f at 0080-017f, 11 maps f800-f87f at 0000-007f.
// - Reset and hardware standby restore the control register, software standby keeps it.
// - A writer mode lets an outside programmer program, erase and verify the array through parallel pins.
// - At supply level the device drives data when select and gate are low and strobe high, else floats.
// - At programming level a byte is taken when select and strobe are low and gate high; reads are as in read mode.
// - There is no automatic identification mode.
// - Erase 20, auto-erase 30 and reset ff need the same code in both cycles, at any address; the code returns to idle on a single ff.
// - Read is a write of 00 then reads; program is 40 then a write of address and data.
// - Program-verify is c0 then a read that returns the last programmed byte's verify data.
// - Erase-verify is a0 with the location, then a read that returns its verify data.
// - Unprogrammed or erased locations read as ff.
package frow_pkg;
   localparam logic [7:0] REG_OVL = 8'h00; // overlap control
   localparam logic [7:0] REG_WST = 8'h04; // writer status
   localparam logic [7:0] REG_WTR = 8'h08; // writer target location
   localparam logic [7:0] OVL_RESET = 8'h08;
   localparam int OVL_SEL_HI = 7;
   localparam int OVL_SEL_LO = 6;
   localparam logic [15:0] RAM_BASE = 16'hf800;
   localparam logic [15:0] RAM_LAST = 16'hf97f;
   localparam logic [15:0] OFS_LO = 16'h0000;
   localparam logic [15:0] OFS_MID = 16'h0080;
   localparam logic [15:0] END_SMALL = 16'h007f;
   localparam logic [15:0] END_MID = 16'h00ff;
   localparam logic [15:0] END_BIG = 16'h017f;
   localparam logic [15:0] RAM_MID = 16'hf880;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_AERASE = 8'h30;
   localparam logic [7:0] CMD_PROG = 8'h40;
   localparam logic [7:0] CMD_EVFY = 8'ha0;
   localparam logic [7:0] CMD_PVFY = 8'hc0;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] BLANK = 8'hff;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   typedef enum logic [5:0] {
      WS_IDLE = 6'b000001,
      WS_READ = 6'b000010,
      WS_ERSU = 6'b000100,
      WS_AESU = 6'b001000,
      WS_PRSU = 6'b010000,
      WS_VFY = 6'b100000
   } frow_wst_e;

   // writer pin sample
   typedef struct packed {
      logic chip_sel_n;
      logic out_gate_n;
      logic wr_strobe_n;
      logic high_voltage_pin;
      logic vpp_present;
      logic [16:0] addr;
      logic [7:0] data;
   } frow_pin_s;
endpackage

// ---- sim/frow_top_assertions.sv ----
// Purpose: port checks of overlay and writer pins
// Assumes: pins pass a two-flop sync
// Notes: bound to frow_top
`timescale 1ns/1ns
module frow_top_assertions (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hw_standby,
   input wire logic writer_mode,
   // register bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // cpu and pins
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_req,
   input wire logic cpu_ram_hit,
   input wire frow_pkg::frow_pin_s pin_in,
   input wire logic data_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst || !ce);
   // pin states held long enough to cross the sync
   sequence s_rd_pins;
      (writer_mode && !hw_standby && pin_in.vpp_present &&
         !pin_in.chip_sel_n && !pin_in.out_gate_n &&
         pin_in.wr_strobe_n)[*4];
   endsequence
   sequence s_cs_off; pin_in.chip_sel_n[*4]; endsequence
   sequence s_og_off; pin_in.out_gate_n[*4]; endsequence
   sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
   a_read_drive: assert property (s_rd_pins |=> !data_oe_n)
      else $error("pins not driven in read");
   a_cs_float: assert property (s_cs_off |=> data_oe_n)
      else $error("driven while deselected");
   a_gate_float: assert property (s_og_off |=> data_oe_n)
      else $error("driven with gate high");
   a_idle_float: assert property (!writer_mode[*4] |=> data_oe_n)
      else $error("driven outside writer mode");
   a_rst_quiet: assert property ($fell(rst) |-> data_oe_n && !s_axi_rvalid)
      else $error("outputs busy after reset");
   a_ar_answer: assert property (s_ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   a_native_hit: assert property (cpu_req && cpu_addr >= frow_pkg::RAM_BASE
      && cpu_addr <= frow_pkg::RAM_LAST |=> cpu_ram_hit)
      else $error("native ram missed");
   a_flash_miss: assert property (cpu_req && cpu_addr >= 16'h0180 &&
      cpu_addr < 16'hf800 |=> !cpu_ram_hit)
      else $error("ram hit outside windows");
endmodule
bind frow_top frow_top_assertions frow_top_assertions_i (.clk, .rst, .ce,
   .hw_standby, .writer_mode, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .cpu_addr, .cpu_req, .cpu_ram_hit, .pin_in, .data_oe_n);

// ---- sim/frow_pm.sv ----
// Purpose: programmer model on the writer pins
// Assumes: one cycle at a time from the bench
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ns
module frow_pm (
   // clock
   input wire logic clk,
   // pins
   output frow_pkg::frow_pin_s pin,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n
);
   frow_pkg::frow_pin_s p = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 17'h0, 8'h00};
   // wire level: the device wins while it drives
   always_comb begin
      pin = p;
      if (!data_oe_n) pin.data = data_out;
   end
   // write cycle, taken at the strobe rise
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      @(posedge clk);
      p.high_voltage_pin <= 1'h1; // strobes high while it moves
      p.addr <= a;
      p.data <= d;
      repeat (3) @(posedge clk);
      p.chip_sel_n <= 1'h0; // gate stays high
      repeat (4) @(posedge clk);
      p.wr_strobe_n <= 1'h0;
      repeat (4) @(posedge clk);
      p.wr_strobe_n <= 1'h1;
      repeat (4) @(posedge clk);
      p.chip_sel_n <= 1'h1;
      p.data <= ~d;
      @(posedge clk);
      p.high_voltage_pin <= 1'h0; // supply level, never ground
   endtask
   // read cycle, bounded wait for the device to drive
   task automatic rd(input logic [16:0] a, output logic [7:0] q);
      int k;
      q = 8'hxx;
      @(posedge clk);
      p.addr <= a;
      p.data <= ~p.data;
      p.chip_sel_n <= 1'h0;
      p.out_gate_n <= 1'h0;
      for (k = 0; k < 20 && data_oe_n !== 1'h0; k++) @(posedge clk);
      if (data_oe_n === 1'h0) q = data_out;
      repeat (2) @(posedge clk);
      p.chip_sel_n <= 1'h1;
      p.out_gate_n <= 1'h1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ---- sim/frow_top_tb.sv ----
// Purpose: self-checking bench for frow_top
// Assumes: ce held high, one bus transfer at a time
// Notes: pin cycles come from frow_pm
`timescale 1ns/1ns
module frow_top_tb;
   logic clk = 1'h0, rst = 1'h1, ce = 1'h1, hw_standby = 1'h0;
   logic writer_mode = 1'h0, cpu_req = 1'h0, cpu_we = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, cpu_wdata = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [15:0] cpu_addr = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, cpu_ram_hit, data_oe_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [7:0] cpu_rdata, data_out, q;
   frow_pkg::frow_pin_s pin_in;
   int n_mismatch = 0, tests_run = 0;
   // 4 ns clock
   always #2 clk = ~clk;
   frow_top frow_top_i (.clk, .rst, .ce, .hw_standby, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_addr,
      .cpu_req, .cpu_we, .cpu_wdata, .cpu_rdata, .cpu_ram_hit, .writer_mode,
      .pin_in, .data_out, .data_oe_n);
   frow_pm frow_pm_i (.clk, .pin(pin_in), .data_out, .data_oe_n);
   // verdict
   task automatic end_of_test;
      if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // compare and count
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         n_mismatch++;
      end
   endtask
   // exhausted wait ends the run
   task automatic hang(input int k);
      if (k >= 40) begin
         n_mismatch++;
         end_of_test;
      end
   endtask
   // bus write, address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      s_axi_bready <= 1'h0;
      hang(k);
   endtask
   // bus read into v and rr
   task automatic axr(input logic [7:0] a);
      int k;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      v = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
      hang(k);
   endtask
   // one cpu access, answer settled on return
   task automatic cm(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      cpu_addr <= a;
      cpu_we <= w;
      cpu_wdata <= d;
      cpu_req <= 1'h1;
      @(posedge clk);
      cpu_req <= 1'h0;
      // the hit flag stands for one cycle only, so look at it mid-cycle
      @(negedge clk);
   endtask
   // pin read compared with a byte
   task automatic rdc(input string n, input logic [16:0] a, input logic [7:0] e);
      frow_pm_i.rd(a, q);
      chk(n, {24'h0, e}, {24'h0, q});
   endtask
   // reset value, unmapped place, hardware standby
   task automatic t_regs;
      axr(frow_pkg::REG_OVL);
      chk("ovl_rst", 32'h8, v);
      axr(8'h40);
      chk("unmapped", {30'h0, frow_pkg::RESP_ERR}, {30'h0, rr});
      axw(frow_pkg::REG_OVL, 32'hc8);
      hw_standby <= 1'h1;
      repeat (2) @(posedge clk);
      hw_standby <= 1'h0;
      axr(frow_pkg::REG_OVL);
      chk("ovl_hws", 32'h8, v);
   endtask
   // each overlay code, seen from both address views
   task automatic t_ovl;
      logic [15:0] n;
      logic [1:0] s;
      for (int i = 1; i < 5; i++) begin
         s = 2'(i);
         n = s == 2'h2 ? 16'hf97f : s == 2'h3 ? 16'hf800 : 16'hf880;
         axw(frow_pkg::REG_OVL, {24'h0, s, 6'h08});
         axr(frow_pkg::REG_OVL);
         chk("ovl_rd", {24'h0, s, 6'h08}, v);
         cm(n, 1'h1, 8'h50);
         cm(n - 16'hf800, 1'h0, 8'h00);
         chk("hit", {31'h0, s != 2'h0}, {31'h0, cpu_ram_hit});
         if (s != 2'h0) chk("alias", 32'h50, {24'h0, cpu_rdata});
         cm(16'h0180, 1'h0, 8'h00);
         cm(n - 16'hf800, 1'h1, {6'h28, s});
         cm(n, 1'h0, 8'h00);
         chk("native", s == 2'h0 ? 32'h50 : {24'h0, 6'h28, s},
            {24'h0, cpu_rdata});
      end
   endtask
   // program, verify, aborted pair
   task automatic t_wrt;
      writer_mode <= 1'h1; // no program or erase bit is set here
      frow_pm_i.wr(17'h0, 8'h00);
      rdc("blank", 17'h5, 8'hff);
      frow_pm_i.wr(17'h0, 8'h40);
      frow_pm_i.wr(17'h5, 8'h3c);
      frow_pm_i.wr(17'h0, 8'hc0);
      rdc("pvfy", 17'h0, 8'h3c);
      frow_pm_i.wr(17'h5, 8'ha0);
      rdc("evfy", 17'h0, 8'h3c);
      frow_pm_i.wr(17'h0, 8'h20);
      frow_pm_i.wr(17'h0, 8'h30);
      axr(frow_pkg::REG_WST);
      chk("abort", {26'h0, frow_pkg::WS_IDLE}, v);
      frow_pm_i.wr(17'h0, 8'h00);
      rdc("kept", 17'h5, 8'h3c);
   endtask
   // matching pairs of each two-cycle code at any address
   task automatic t_cmd;
      logic [7:0] c[3] = '{8'h20, 8'h30, 8'hff};
      for (int i = 0; i < 3; i++) begin
         frow_pm_i.wr(17'h0, 8'h40);
         frow_pm_i.wr(17'h9, 8'h12);
         frow_pm_i.wr(17'h1ffff, c[i]);
         frow_pm_i.wr(17'h3, c[i]);
         frow_pm_i.wr(17'h0, 8'h00);
         rdc("pair", 17'h9, i == 2 ? 8'h12 : 8'hff);
      end
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      t_regs;
      t_ovl;
      t_wrt;
      t_cmd;
      end_of_test;
   end
endmodule
